// ==== hdl/msd_consts.svh ====
// Purpose: Offsets, field positions and reset values of the mode select block.
// Assumes: APB byte addresses, one register per aligned 32-bit word.
// Notes: Definitions only.
`ifndef MSD_CONSTS_SVH
`define MSD_CONSTS_SVH

// Register byte offsets.
`define MSD_OFF_MODE 8'h00
`define MSD_OFF_MAP 8'h04

// Mode register field positions.
`define MSD_BIT_BOOT 7
`define MSD_BIT_SPECIAL 6
`define MSD_BIT_EXPANDED 5
`define MSD_BIT_ECHO 4

// Map register: register block page in [7:4], RAM page in [3:0].
`define MSD_MAP_REG_MSB 7
`define MSD_MAP_REG_LSB 4
`define MSD_MAP_RAM_MSB 3
`define MSD_MAP_RAM_LSB 0
`define MSD_RST_REG_PAGE 4'h1
`define MSD_RST_RAM_PAGE 4'h0

// Address spans inside a 4-Kbyte page.
`define MSD_REG_SPAN_MSB 11
`define MSD_REG_SPAN_LSB 6
`define MSD_RAM_SPAN_MSB 11
`define MSD_RAM_SPAN_LSB 8

// Boot ROM window.
`define MSD_ROM_LO 16'hbf40
`define MSD_ROM_HI 16'hbfff

// Register offsets 0..7 that belong to the emulated ports and their handshake.
`define MSD_EMUL_OFFS_MASK 8'hbc

`endif

// ==== hdl/msd_pkg.sv ====
// Purpose: Types shared by the mode select block and its bench.
// Assumes: Nothing beyond SystemVerilog packed types.
// Notes: Constants live in msd_consts.svh.
package msd_pkg;

  // One CPU bus cycle, presented for one clock when valid is high.
  typedef struct packed {
    logic valid;
    logic first_op;
    logic read;
    logic [15:0] addr;
    logic [7:0] rdata;
  } msd_cpu_cycle_t;

  // Mode control bits held after reset.
  typedef struct packed {
    logic boot;
    logic special;
    logic expanded;
    logic echo;
  } msd_mode_t;

  // Operating mode, Gray coded along single, expanded, test, bootstrap.
  typedef enum logic [1:0] {
    MSD_SINGLE = 2'b00,
    MSD_EXPANDED = 2'b01,
    MSD_TEST = 2'b11,
    MSD_BOOT = 2'b10
  } msd_op_mode_t;

endpackage

// ==== hdl/msd_mode_ctrl.sv ====
// Purpose: Mode capture at reset, mode control bits, fetch marker, read echo and decode.
// Assumes: One 20 MHz clock; srst_in is the device reset, high while in reset.
// Notes: Mode pins and the external interrupt pin pass two flip-flops before use.
`include "msd_consts.svh"

// Behaviour
// - Marker low on first cycle of instruction.
// - Echo enabled drives internal read data out.
// - Echo disabled leaves data bus undriven.
// - Normal mode reset clears echo enable.
// - Special reset sets echo; clear locks it.
// - Legacy normal mode cannot set echo.
// - Newer variant sets echo unless cleared before.
// - Expanded mode sends emulated port addresses out.
// - Handshake interrupts share external interrupt vector.
// - Register block and RAM relocate per 4K.
// - Mode pins captured through clocked pipeline.
// - Special is not pin B; expanded is A.
// - Boot ROM when both low; echo when B low.
// - Pins ignored after reset; A becomes marker.
// - Bootstrap mode enables serial program load.
// - Only special modes may change the mode.
// - Expanded modes release the eighteen port pins.
// - Special flag clears but never sets again.
// - Boot and expanded writable only while special.
// - Boot ROM off removes it from map.
module msd_mode_ctrl
  import msd_pkg::*;
#(
  parameter bit NEW_VARIANT = 1'b1
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic srst_in,
  // APB slave.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Mode pins; pin A doubles as the open-drain fetch marker.
  input wire logic mode_pin_a_in,
  output logic mode_pin_a_out,
  output logic mode_pin_a_oe_out,
  input wire logic mode_pin_b_in,
  // CPU bus cycle.
  input wire msd_cpu_cycle_t cpu_cycle_in,
  // Interrupts.
  input wire logic ext_irq_in,
  input wire logic hs_irq_in,
  output logic irq_req_out,
  // External data bus for read echo.
  output logic [7:0] ext_data_out,
  output logic ext_data_oe_out,
  // Address decode.
  output logic ext_access_out,
  output logic sel_reg_out,
  output logic sel_ram_out,
  output logic sel_boot_rom_out,
  // Mode status.
  output msd_op_mode_t op_mode_out,
  output logic port_io_released_out,
  output logic serial_boot_enable_out
);

  // Bit 0 is mode pin A, bit 1 mode pin B, bit 2 the external interrupt pin.
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  msd_mode_t mode;
  logic echo_locked;
  logic [3:0] reg_page;
  logic [3:0] ram_page;
  logic access;
  logic addr_ok;
  logic wr_fire;
  logic wr_mode;
  logic wr_map;
  logic [31:0] rd_value;
  logic in_reg;
  logic in_ram;
  logic in_rom;
  logic emul;
  logic int_hit;
  logic echo_now;
  // Register offsets that belong to the port emulator while the bus is expanded.
  localparam logic [7:0] EMUL_MASK = `MSD_EMUL_OFFS_MASK;

  always_ff @(posedge clk_in) begin
    pin_s1 <= {ext_irq_in, mode_pin_b_in, mode_pin_a_in};
    pin_s2 <= pin_s1;
  end

  assign access = psel_in & penable_in;
  assign addr_ok = (paddr_in == `MSD_OFF_MODE) || (paddr_in == `MSD_OFF_MAP);
  assign wr_fire = access & pready_out & pwrite_in & addr_ok;
  assign wr_mode = wr_fire && (paddr_in == `MSD_OFF_MODE);
  assign wr_map = wr_fire && (paddr_in == `MSD_OFF_MAP);

  always_comb begin
    rd_value = 32'h0000_0000;
    if (paddr_in == `MSD_OFF_MODE) begin
      rd_value[`MSD_BIT_BOOT] = mode.boot;
      rd_value[`MSD_BIT_SPECIAL] = mode.special;
      rd_value[`MSD_BIT_EXPANDED] = mode.expanded;
      rd_value[`MSD_BIT_ECHO] = mode.echo;
    end else if (paddr_in == `MSD_OFF_MAP) begin
      rd_value[`MSD_MAP_REG_MSB:`MSD_MAP_REG_LSB] = reg_page;
      rd_value[`MSD_MAP_RAM_MSB:`MSD_MAP_RAM_LSB] = ram_page;
    end
  end

  // The access phase always takes two cycles; pready rises in the second.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= access & ~pready_out;
      prdata_out <= rd_value;
      pslverr_out <= access & ~pready_out & ~addr_ok;
    end
  end

  // hold until reset
  // Mode bits: loaded from the pins every reset cycle, written by software after.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mode.special <= ~pin_s2[1];
      mode.expanded <= pin_s2[0];
      mode.boot <= ~pin_s2[1] & ~pin_s2[0];
      mode.echo <= ~pin_s2[1];
      echo_locked <= 1'b0;
    end else if (wr_mode) begin
      if (!pwdata_in[`MSD_BIT_SPECIAL]) begin
        mode.special <= 1'b0;
      end
      if (mode.special) begin
        mode.boot <= pwdata_in[`MSD_BIT_BOOT];
        mode.expanded <= pwdata_in[`MSD_BIT_EXPANDED];
      end
      if (!pwdata_in[`MSD_BIT_ECHO]) begin
        mode.echo <= 1'b0;
        echo_locked <= 1'b1;
      end else if (!echo_locked && (NEW_VARIANT || mode.special)) begin
        mode.echo <= 1'b1;
      end
      // The legacy part forces echo off once normal mode is entered.
      if (!NEW_VARIANT && !pwdata_in[`MSD_BIT_SPECIAL]) begin
        mode.echo <= 1'b0;
        echo_locked <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      reg_page <= `MSD_RST_REG_PAGE;
      ram_page <= `MSD_RST_RAM_PAGE;
    end else if (wr_map) begin
      reg_page <= pwdata_in[`MSD_MAP_REG_MSB:`MSD_MAP_REG_LSB];
      ram_page <= pwdata_in[`MSD_MAP_RAM_MSB:`MSD_MAP_RAM_LSB];
    end
  end

  // Register block wins over RAM, and both over the boot ROM.
  always_comb begin
    in_reg = (cpu_cycle_in.addr[15:12] == reg_page) &&
             (cpu_cycle_in.addr[`MSD_REG_SPAN_MSB:`MSD_REG_SPAN_LSB] == 6'h00);
    in_ram = (cpu_cycle_in.addr[15:12] == ram_page) && !in_reg &&
             (cpu_cycle_in.addr[`MSD_RAM_SPAN_MSB:`MSD_RAM_SPAN_LSB] == 4'h0);
    in_rom = mode.boot && !in_reg && !in_ram && (cpu_cycle_in.addr >= `MSD_ROM_LO) &&
             (cpu_cycle_in.addr <= `MSD_ROM_HI);
    emul = in_reg && mode.expanded && (cpu_cycle_in.addr[5:3] == 3'h0) &&
           EMUL_MASK[cpu_cycle_in.addr[2:0]];
    int_hit = (in_reg && !emul) || in_ram || in_rom;
    echo_now = cpu_cycle_in.valid && cpu_cycle_in.read && int_hit && mode.echo;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sel_reg_out <= 1'b0;
      sel_ram_out <= 1'b0;
      sel_boot_rom_out <= 1'b0;
      ext_access_out <= 1'b0;
    end else begin
      sel_reg_out <= cpu_cycle_in.valid && in_reg && !emul;
      sel_ram_out <= cpu_cycle_in.valid && in_ram;
      sel_boot_rom_out <= cpu_cycle_in.valid && in_rom;
      ext_access_out <= cpu_cycle_in.valid && !int_hit;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ext_data_oe_out <= 1'b0;
      ext_data_out <= 8'h00;
    end else begin
      ext_data_oe_out <= echo_now;
      ext_data_out <= echo_now ? cpu_cycle_in.rdata : 8'h00;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mode_pin_a_oe_out <= 1'b0;
    end else begin
      mode_pin_a_oe_out <= cpu_cycle_in.valid && cpu_cycle_in.first_op;
    end
  end

  always_ff @(posedge clk_in) begin
    mode_pin_a_out <= 1'b0;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_req_out <= 1'b0;
    end else begin
      irq_req_out <= pin_s2[2] | hs_irq_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      op_mode_out <= MSD_SINGLE;
      port_io_released_out <= 1'b0;
      serial_boot_enable_out <= 1'b0;
    end else begin
      unique case ({mode.special, mode.expanded})
        2'b00: op_mode_out <= MSD_SINGLE;
        2'b01: op_mode_out <= MSD_EXPANDED;
        2'b11: op_mode_out <= MSD_TEST;
        2'b10: op_mode_out <= MSD_BOOT;
      endcase
      port_io_released_out <= mode.expanded;
      serial_boot_enable_out <= mode.special && !mode.expanded && mode.boot;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  marker_timing_a: assert property (
    ##1 (mode_pin_a_oe_out == $past(cpu_cycle_in.valid & cpu_cycle_in.first_op)))
    else $error("fetch marker not matched to first instruction cycle");

  echo_drive_a: assert property (
    echo_now |=> ext_data_oe_out && (ext_data_out == $past(cpu_cycle_in.rdata)))
    else $error("internal read data not echoed");

  echo_quiet_a: assert property (
    !mode.echo |=> !ext_data_oe_out)
    else $error("data bus driven with echo disabled");

  capture_normal_a: assert property (
    $fell(srst_in) && $past(pin_s2[1]) |-> !mode.echo && !mode.special && !mode.boot)
    else $error("normal mode reset left echo or special set");

  capture_pins_a: assert property (
    $fell(srst_in) |-> (mode.special == !$past(pin_s2[1])) &&
      (mode.expanded == $past(pin_s2[0])) && (mode.echo == !$past(pin_s2[1])) &&
      (mode.boot == (!$past(pin_s2[1]) && !$past(pin_s2[0]))))
    else $error("mode bits differ from captured pins");

  echo_lock_a: assert property (
    echo_locked |-> !mode.echo)
    else $error("echo enabled after being cleared");

  legacy_set_a: assert property (
    !NEW_VARIANT && !mode.special && !mode.echo |=> !mode.echo)
    else $error("legacy normal mode set echo");

  emul_external_a: assert property (
    cpu_cycle_in.valid && emul |=> ext_access_out && !sel_reg_out)
    else $error("emulated port address kept internal");

  irq_merge_a: assert property (
    hs_irq_in |=> irq_req_out)
    else $error("handshake interrupt not on shared request");

  special_stick_a: assert property (
    !mode.special |=> !mode.special)
    else $error("special flag set again");

  mode_locked_a: assert property (
    !mode.special |=> $stable(mode.expanded) && $stable(mode.boot))
    else $error("mode bits changed outside special mode");

  mode_hold_a: assert property (
    !wr_mode |=> $stable(mode))
    else $error("mode bits changed without a write");

  rom_hidden_a: assert property (
    !mode.boot |=> !sel_boot_rom_out)
    else $error("boot ROM selected while disabled");

  reg_reloc_a: assert property (
    cpu_cycle_in.valid && in_reg && !emul |=>
      sel_reg_out && ($past(cpu_cycle_in.addr[15:12]) == $past(reg_page)))
    else $error("relocated register block not selected");

  marker_level_a: assert property (
    mode_pin_a_oe_out |-> !mode_pin_a_out)
    else $error("fetch marker driven high");

  pins_ignored_a: assert property (
    $changed(pin_s2[1:0]) && !wr_mode |=> $stable(mode))
    else $error("mode bits followed the pins after reset");

  echo_clear_a: assert property (
    wr_mode && !pwdata_in[`MSD_BIT_ECHO] |=> !mode.echo && echo_locked)
    else $error("echo clear did not lock the function off");

  port_release_a: assert property (
    !srst_in |=> (port_io_released_out == $past(mode.expanded)))
    else $error("port pin release does not follow expanded bit");

  test_entry_c: cover property (
    $fell(srst_in) ##0 (mode.special && mode.expanded));
  echo_cleared_c: cover property (
    mode.echo ##1 echo_locked);
  marker_pulse_c: cover property (
    !mode_pin_a_oe_out ##1 mode_pin_a_oe_out ##1 !mode_pin_a_oe_out);
  echo_seen_c: cover property (
    ext_data_oe_out && mode.special);

endmodule

// ==== sim/msd_far_side.sv ====
// Purpose: Far side of the block: pulled-up mode pin A and the external data bus.
// Assumes: The bench sets the strap level that pin A shows when nothing pulls it low.
// Notes: An undriven data bus shows the inverse of its last value.
module msd_far_side (
  // Clock.
  input wire logic clk_in,
  // Pin A.
  input wire logic strap_a_in,
  input wire logic pin_a_drv_in,
  input wire logic pin_a_oe_in,
  output logic pin_a_out,
  // Data bus.
  input wire logic [7:0] dev_data_in,
  input wire logic dev_data_oe_in,
  output logic [7:0] data_bus_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last_bus;
  assign pin_a_out = pin_a_oe_in ? pin_a_drv_in : strap_a_in;
  // stay off bus: outside devices never drive while the device echoes.
  assign data_bus_out = dev_data_oe_in ? dev_data_in : ~last_bus;
  always_ff @(posedge clk_in) begin
    last_bus <= data_bus_out;
  end
endmodule

// ==== sim/msd_mode_ctrl_tb.sv ====
// Purpose: Self-checking bench of the mode select block in all four modes.
// Assumes: Newer variant; APB answers with pready, taken at that edge.
// Notes: Random read data come from an 8-bit LFSR seeded with 73.
module msd_mode_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import msd_pkg::*;
  logic clk_in = 0, srst_in = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, lf = 8'h49, x;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e, strap_a = 0, pin_a, pin_b = 0, a_drv, a_oe, ext_irq = 0, hs_irq = 0;
  logic irq, dat_oe, ext_acc, s_reg, s_ram, s_rom, rel, sboot;
  logic [7:0] dat, bus;
  logic [3:0] em;
  msd_cpu_cycle_t cpu = '0;
  msd_op_mode_t op;
  int miscompares = 0, comparisons = 0, cyc = 0;
  always #25 clk_in = ~clk_in;
  msd_mode_ctrl #(.NEW_VARIANT(1'b1)) msd_mode_ctrl_inst (.clk_in(clk_in), .srst_in(srst_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .mode_pin_a_in(pin_a), .mode_pin_a_out(a_drv), .mode_pin_a_oe_out(a_oe),
    .mode_pin_b_in(pin_b), .cpu_cycle_in(cpu), .ext_irq_in(ext_irq), .hs_irq_in(hs_irq),
    .irq_req_out(irq), .ext_data_out(dat), .ext_data_oe_out(dat_oe), .ext_access_out(ext_acc),
    .sel_reg_out(s_reg), .sel_ram_out(s_ram), .sel_boot_rom_out(s_rom), .op_mode_out(op),
    .port_io_released_out(rel), .serial_boot_enable_out(sboot));
  msd_far_side msd_far_side_inst (.clk_in(clk_in), .strap_a_in(strap_a), .pin_a_drv_in(a_drv),
    .pin_a_oe_in(a_oe), .pin_a_out(pin_a), .dev_data_in(dat), .dev_data_oe_in(dat_oe),
    .data_bus_out(bus));
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Mode bits latched at reset: boot, special, expanded, echo.
  function automatic logic [3:0] exp_mode(input logic b, input logic a);
    return {!b & !a, !b, a, !b};
  endfunction
  task automatic final_report();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] ex, input logic [7:0] g);
    comparisons++;
    if (g !== ex) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, ex, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge clk_in);
    penable <= 1;
    do begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic cpu_cyc(input logic fo, input logic [15:0] ad);
    lf = lfsr(lf);
    x = lf;
    @(posedge clk_in);
    cpu <= {1'b1, fo, 1'b1, ad, x};
    @(posedge clk_in);
    cpu <= '0;
    #1;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    for (int m = 0; m < 4; m++) begin
      strap_a <= m[0]; pin_b <= m[1]; srst_in <= 1;
      repeat (20) @(posedge clk_in);
      srst_in <= 0; strap_a <= ~m[0]; pin_b <= ~m[1];
      em = exp_mode(m[1], m[0]);
      apb(0, 8'h00, 0); chk("mode", em, r[7:4]);
      chk("slverr", 0, e);
      @(posedge clk_in); #1;
      chk("op_mode", {!m[1], m[0]}, op);
      chk("released", m[0], rel);
      chk("serial_boot", em[3], sboot);
      apb(0, 8'h04, 0); chk("map", 8'h10, r[7:0]);
      cpu_cyc(1, 16'h1010); chk("marker", 1, a_oe);
      chk("marker_pin", 0, pin_a);
      chk("echo_oe", !m[1], dat_oe);
      chk("sel_reg", 1, s_reg);
      if (!m[1]) chk("bus", x, bus);
      cpu_cyc(0, 16'h1002); chk("marker", 0, a_oe);
      chk("ext", m[0], ext_acc);
      cpu_cyc(0, 16'hbf50); chk("rom", em[3], s_rom);
      cpu_cyc(0, 16'h0050); chk("sel_ram", 1, s_ram);
      apb(1, 8'h00, {em[3:1], 1'b1, 4'h0}); apb(0, 8'h00, 0);
      chk("echo_set", 1, r[4]);
      apb(1, 8'h00, {em[3:1], 1'b0, 4'h0}); apb(1, 8'h00, {em[3:1], 1'b1, 4'h0});
      apb(0, 8'h00, 0); chk("echo_lock", 0, r[4]);
      apb(1, 8'h00, 0); apb(1, 8'h00, 32'he0); apb(0, 8'h00, 0);
      chk("mode_lock", {2'b00, m[1] & m[0], 1'b0}, r[7:4]);
      apb(1, 8'h04, 32'h20); cpu_cyc(0, 16'h2010); chk("reloc", 1, s_reg);
      apb(0, 8'h08, 0); chk("unmapped", 1, e);
      $display("mode %0d done", m);
    end
    hs_irq <= 1;
    repeat (2) @(posedge clk_in);
    #1 chk("hs_irq", 1, irq);
    @(posedge clk_in);
    hs_irq <= 0; ext_irq <= 1;
    repeat (2) @(posedge clk_in);
    #1 chk("ext_irq_sync", 0, irq);
    @(posedge clk_in);
    #1 chk("ext_irq", 1, irq);
    $display("interrupt test done");
    final_report();
  end
endmodule
